// *** hdl/flash_pkg.sv ***
// Purpose: shared constants and types of the flash self-programming sequencer
// Assumes: one 40 MHz clock; program words are 24 bits wide
// Notes: the flash array is modelled small; its depth is ARRAY_WORDS
package flash_pkg;
  localparam int ROW_WORDS = 64;
  localparam int ROW_BYTES = 192;
  localparam int PAGE_ROWS = 8;
  localparam int PAGE_WORDS = ROW_WORDS * PAGE_ROWS;
  localparam int PAGE_BYTES = 1536;
  localparam int ARRAY_WORDS = 2048;
  localparam int AW = 11;
  // control register layout
  localparam int CTL_START = 15;
  localparam int CTL_ENABLE = 14;
  localparam int CTL_ERROR = 13;
  localparam int CTL_ERASE = 6;
  localparam int CTL_OP_MSB = 3;
  localparam logic [3:0] OP_ROW_WRITE = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
  localparam logic [3:0] OP_WORD_WRITE = 4'h3;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
  // operation lengths in oscillator cycles
  localparam int ROW_FRC_DEF = 11064;
  localparam int PAGE_FRC_DEF = 11064;
  localparam int WORD_FRC_DEF = 400;
  // oscillator model: phase accumulator stepped at the system clock
  localparam int FRC_KHZ = 7370;
  localparam int MCLK_KHZ = 40000;
  localparam int FRC_INC_NOM = (FRC_KHZ * 65536 + MCLK_KHZ / 2) / MCLK_KHZ;
  localparam int TUNE_STEP_PPM = 3750;
  localparam int FRC_INC_STEP = (FRC_INC_NOM * TUNE_STEP_PPM + 500000) / 1000000;
  // link operations
  typedef enum logic [2:0] {
    OP_TBL_WR_LO,
    OP_TBL_WR_HI,
    OP_TBL_RD_LO,
    OP_TBL_RD_HI,
    OP_CTL_WR,
    OP_CTL_RD,
    OP_KEY_WR
  } link_op_t;
  // controller register map (byte addresses)
  localparam logic [4:0] REG_PAGE = 5'h00;
  localparam logic [4:0] REG_EA = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_CMD = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_EVENTS = 5'h14;
  localparam logic [4:0] REG_MASK = 5'h18;
  localparam logic [4:0] REG_STATE = 5'h1C;
  localparam int CMD_BYTE = 4;
  localparam int EV_LINK = 0;
  localparam int EV_FLASH = 1;
  localparam int EV_W = 2;
endpackage

// *** hdl/flash_link_if.sv ***
// Purpose: link between the processor-side port and the flash sequencer
// Assumes: both ends run on mclk_in
// Notes: req is a one-cycle pulse, done answers every taken req
interface flash_link_if;
  logic req;
  flash_pkg::link_op_t op;
  logic byte_mode;
  logic [7:0] page;
  logic [15:0] ea;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  logic stall;
  modport device (
    input req, op, byte_mode, page, ea, wdata,
    output done, rdata, stall
  );
  modport core (
    output req, op, byte_mode, page, ea, wdata,
    input done, rdata, stall
  );
endinterface

// *** hdl/flash_sequencer.sv ***
// Purpose: flash self-programming sequencer with row holding buffer
// Assumes: the core sends one request at a time and waits for done
// Notes: timing follows an oscillator model trimmed by the tuning input
// How it works
// RULE1 - array rows hold 64 instructions
// RULE2 - erase eight-row page; program row or word
// RULE3 - pages and rows aligned from memory start
// RULE4 - core fills holding buffer in address order
// RULE5 - buffered words share one 64-word group
// RULE6 - address is table page above effective address
// RULE7 - low table access uses bits 15..0
// RULE8 - high table access uses bits 23..16
// RULE9 - core issues 64 table writes per row
// RULE10 - table write: two cycles, buffer only
// RULE11 - one start programs at most one row
// RULE12 - core stalls until operation completes
// RULE13 - row write lasts 11064 oscillator cycles
// RULE14 - start bit set by software, cleared by hardware
// RULE15 - core triggers operation via control register
// RULE16 - core writes 0x55 then 0xAA to unlock
// RULE17 - start without fresh unlock is ignored
module flash_sequencer #(
  parameter int ROW_FRC_CYCLES = flash_pkg::ROW_FRC_DEF,
  parameter int PAGE_FRC_CYCLES = flash_pkg::PAGE_FRC_DEF,
  parameter int WORD_FRC_CYCLES = flash_pkg::WORD_FRC_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [5:0] oscillator_tuning_field_in,
  output logic flash_busy_out,
  flash_link_if.device link
);
  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;
  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_state_t;

  logic [23:0] holding_q [flash_pkg::ROW_WORDS];
  logic [23:0] array_q [flash_pkg::ARRAY_WORDS];
  seq_state_t state_q;
  key_state_t key_q;
  logic take;
  logic table_op;
  logic [22:0] word_addr;
  logic addr_ok;
  logic [23:0] rd_word;
  logic [22:0] tgt_q;
  logic start_q;
  logic enable_q;
  logic error_q;
  logic erase_q;
  logic [3:0] nvop_q;
  logic [15:0] ctl_word;
  logic start_req;
  logic op_ok;
  logic go;
  logic word_mode;
  logic [9:0] cnt_q;
  logic [9:0] run_len;
  logic [22:0] prog_base;
  logic [22:0] prog_addr;
  logic [23:0] prog_data;
  logic [15:0] phase_q;
  logic [16:0] phase_sum;
  int tune_inc;
  logic [15:0] frc_cnt_q;
  logic [15:0] frc_target;
  logic finish;
  logic slow_q;
  logic done_q;
  logic stall_q;
  logic [15:0] rdata_q;

  //////////////////////////////////////////////////////////////////////
  // request decode
  // no request is taken while an operation runs
  assign take = link.req && state_q == ST_IDLE; // RULE12

  always_comb begin
    word_addr = {link.page, link.ea[15:1]}; // RULE6
    // configuration space and space beyond the model read as zero
    addr_ok = !link.page[7] && (word_addr < 23'(flash_pkg::ARRAY_WORDS));
    rd_word = addr_ok ? array_q[word_addr[flash_pkg::AW-1:0]] : 24'h000000;
    table_op = link.op inside {flash_pkg::OP_TBL_WR_LO, flash_pkg::OP_TBL_WR_HI,
                               flash_pkg::OP_TBL_RD_LO, flash_pkg::OP_TBL_RD_HI};
    ctl_word = {start_q, enable_q, error_q, 6'h00, erase_q, 2'b00, nvop_q};
  end

  always_comb begin
    start_req = take && link.op == flash_pkg::OP_CTL_WR && link.wdata[flash_pkg::CTL_START];
    if (link.wdata[flash_pkg::CTL_ERASE]) begin
      op_ok = link.wdata[flash_pkg::CTL_OP_MSB:0] == flash_pkg::OP_PAGE_ERASE;
    end else begin
      op_ok = link.wdata[flash_pkg::CTL_OP_MSB:0] inside
              {flash_pkg::OP_ROW_WRITE, flash_pkg::OP_WORD_WRITE};
    end
    // a start needs the enable bit, a legal op and the unlock just before
    go = start_req && link.wdata[flash_pkg::CTL_ENABLE] && key_q == KEY_OPEN && op_ok; // RULE17
  end

  //////////////////////////////////////////////////////////////////////
  // unlock sequence: any other request in between relocks
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      key_q <= KEY_LOCKED;
    end else if (take) begin
      if (link.op == flash_pkg::OP_KEY_WR && link.wdata[7:0] == flash_pkg::KEY_FIRST) begin
        key_q <= KEY_HALF; // RULE16
      end else if (link.op == flash_pkg::OP_KEY_WR && key_q == KEY_HALF &&
                   link.wdata[7:0] == flash_pkg::KEY_SECOND) begin
        key_q <= KEY_OPEN; // RULE16
      end else begin
        key_q <= KEY_LOCKED;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_q <= 1'b0;
      error_q <= 1'b0;
      erase_q <= 1'b0;
      nvop_q <= 4'h0;
    end else if (take && link.op == flash_pkg::OP_CTL_WR) begin
      if (go) begin
        enable_q <= link.wdata[flash_pkg::CTL_ENABLE];
        error_q <= 1'b0;
        erase_q <= link.wdata[flash_pkg::CTL_ERASE];
        nvop_q <= link.wdata[flash_pkg::CTL_OP_MSB:0];
      end else if (start_req) begin
        // refused start: flag it, touch nothing else
        error_q <= 1'b1; // RULE17
      end else begin
        enable_q <= link.wdata[flash_pkg::CTL_ENABLE];
        error_q <= link.wdata[flash_pkg::CTL_ERROR];
        erase_q <= link.wdata[flash_pkg::CTL_ERASE];
        nvop_q <= link.wdata[flash_pkg::CTL_OP_MSB:0];
      end
    end
  end

  // start bit is settable only; hardware clears it at the end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      stall_q <= 1'b0;
    end else if (go) begin
      state_q <= ST_RUN;
      start_q <= 1'b1; // RULE14
      stall_q <= 1'b1; // RULE12
    end else if (finish) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0; // RULE14
      stall_q <= 1'b0; // RULE12
    end
  end

  //////////////////////////////////////////////////////////////////////
  // holding buffer: table writes land here, never in the array
  always_ff @(posedge mclk_in) begin
    if (take && link.op == flash_pkg::OP_TBL_WR_LO) begin
      if (!link.byte_mode) begin
        holding_q[link.ea[6:1]][15:0] <= link.wdata; // RULE7 RULE10
      end else if (link.ea[0]) begin
        holding_q[link.ea[6:1]][15:8] <= link.wdata[7:0]; // RULE7
      end else begin
        holding_q[link.ea[6:1]][7:0] <= link.wdata[7:0]; // RULE7
      end
    end else if (take && link.op == flash_pkg::OP_TBL_WR_HI) begin
      // the phantom byte above bit 23 is not stored
      if (!link.byte_mode || !link.ea[0]) begin
        holding_q[link.ea[6:1]][23:16] <= link.wdata[7:0]; // RULE8 RULE10
      end
    end
  end

  // last table write address picks the row, word or page to program
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tgt_q <= 23'h000000;
    end else if (take && link.op inside {flash_pkg::OP_TBL_WR_LO, flash_pkg::OP_TBL_WR_HI}) begin
      tgt_q <= word_addr; // RULE6
    end
  end

  //////////////////////////////////////////////////////////////////////
  // self-timed operation
  always_comb begin
    word_mode = nvop_q == flash_pkg::OP_WORD_WRITE;
    if (erase_q) begin
      run_len = 10'(flash_pkg::PAGE_WORDS); // RULE2
      prog_base = {tgt_q[22:9], 9'h000}; // RULE3
      prog_data = flash_pkg::ERASED_WORD;
      frc_target = 16'(PAGE_FRC_CYCLES);
    end else if (word_mode) begin
      run_len = 10'h001; // RULE2
      prog_base = tgt_q;
      prog_data = holding_q[tgt_q[5:0]];
      frc_target = 16'(WORD_FRC_CYCLES);
    end else begin
      run_len = 10'(flash_pkg::ROW_WORDS); // RULE1 RULE11
      prog_base = {tgt_q[22:6], 6'h00}; // RULE3
      prog_data = holding_q[cnt_q[5:0]];
      frc_target = 16'(ROW_FRC_CYCLES); // RULE13
    end
    prog_addr = prog_base + 23'(cnt_q);
    finish = state_q == ST_RUN && cnt_q == run_len && frc_cnt_q >= frc_target;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 10'h000;
    end else if (go) begin
      cnt_q <= 10'h000;
    end else if (state_q == ST_RUN && cnt_q != run_len) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  // one word per clock; the rest of the time is the oscillator wait
  always_ff @(posedge mclk_in) begin
    if (state_q == ST_RUN && cnt_q != run_len &&
        prog_addr < 23'(flash_pkg::ARRAY_WORDS)) begin
      array_q[prog_addr[flash_pkg::AW-1:0]] <= prog_data; // RULE2 RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////
  // oscillator model: tuning field is signed, one step per 0.375 percent
  always_comb begin
    tune_inc = flash_pkg::FRC_INC_NOM +
               $signed(oscillator_tuning_field_in) * flash_pkg::FRC_INC_STEP;
    phase_sum = {1'b0, phase_q} + 17'(tune_inc);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= 16'h0000;
    end else begin
      phase_q <= phase_sum[15:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      frc_cnt_q <= 16'h0000;
    end else if (go) begin
      frc_cnt_q <= 16'h0000;
    end else if (state_q == ST_RUN && phase_sum[16] && frc_cnt_q != 16'hFFFF) begin
      frc_cnt_q <= frc_cnt_q + 16'h0001; // RULE13
    end
  end

  //////////////////////////////////////////////////////////////////////
  // answers: table operations take two cycles, the rest one
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      slow_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      slow_q <= take && table_op;
      done_q <= (take && !table_op) || slow_q; // RULE10
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (take) begin
      unique case (link.op)
        flash_pkg::OP_TBL_RD_LO: begin
          if (!link.byte_mode) begin
            rdata_q <= rd_word[15:0]; // RULE7
          end else begin
            rdata_q <= {8'h00, link.ea[0] ? rd_word[15:8] : rd_word[7:0]}; // RULE7
          end
        end
        flash_pkg::OP_TBL_RD_HI: begin
          if (link.byte_mode && link.ea[0]) begin
            rdata_q <= 16'h0000;
          end else begin
            rdata_q <= {8'h00, rd_word[23:16]}; // RULE8
          end
        end
        flash_pkg::OP_CTL_RD: rdata_q <= ctl_word;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign link.done = done_q;
  assign link.rdata = rdata_q;
  assign link.stall = stall_q;
  assign flash_busy_out = stall_q;
endmodule

// *** hdl/flash_core_port.sv ***
// Purpose: processor-side end: software orders table and control accesses
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data
// Notes: a command write is held off by waitrequest while the link is busy
module flash_core_port (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  flash_link_if.core link
);
  logic wait_q;
  logic [31:0] readdata_q;
  logic [7:0] page_q;
  logic [15:0] ea_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [flash_pkg::EV_W-1:0] events_q;
  logic [flash_pkg::EV_W-1:0] mask_q;
  logic [flash_pkg::EV_W-1:0] rd_events_q;
  logic [flash_pkg::EV_W-1:0] ev_set;
  logic req_q;
  flash_pkg::link_op_t op_q;
  logic byte_q;
  logic pend_q;
  logic stall_prev_q;
  logic irq_q;
  logic is_cmd;
  logic can_go;
  logic accept;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////
  // bus slave
  always_comb begin
    is_cmd = avs_write_in && avs_address_in == flash_pkg::REG_CMD;
    // the core may not issue while a request is out or flash is busy
    can_go = !is_cmd || (!pend_q && !req_q && !link.stall); // RULE12
    accept = !wait_q && (avs_read_in || avs_write_in);
    unique case (avs_address_in)
      flash_pkg::REG_PAGE: rd_mux = {24'h000000, page_q};
      flash_pkg::REG_EA: rd_mux = {16'h0000, ea_q};
      flash_pkg::REG_WDATA: rd_mux = {16'h0000, wdata_q};
      flash_pkg::REG_RDATA: rd_mux = {16'h0000, rdata_q};
      flash_pkg::REG_EVENTS: rd_mux = {30'h00000000, events_q};
      flash_pkg::REG_MASK: rd_mux = {30'h00000000, mask_q};
      flash_pkg::REG_STATE: rd_mux = {30'h00000000, link.stall, pend_q | req_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // waitrequest drops for one cycle; the access acts at that edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      readdata_q <= 32'h00000000;
      rd_events_q <= '0;
    end else if (wait_q && (avs_read_in || avs_write_in) && can_go) begin
      wait_q <= 1'b0;
      readdata_q <= rd_mux;
      rd_events_q <= (avs_read_in && avs_address_in == flash_pkg::REG_EVENTS) ? events_q : '0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      page_q <= 8'h00;
      ea_q <= 16'h0000;
      wdata_q <= 16'h0000;
      mask_q <= '0;
    end else if (accept && avs_write_in) begin
      unique case (avs_address_in)
        flash_pkg::REG_PAGE: page_q <= avs_writedata_in[7:0];
        flash_pkg::REG_EA: ea_q <= avs_writedata_in[15:0];
        flash_pkg::REG_WDATA: wdata_q <= avs_writedata_in[15:0];
        flash_pkg::REG_MASK: mask_q <= avs_writedata_in[flash_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // link requests: software keeps the fill order, group and key sequence
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      req_q <= 1'b0;
      op_q <= flash_pkg::OP_CTL_RD;
      byte_q <= 1'b0;
    end else if (accept && is_cmd) begin
      req_q <= 1'b1; // RULE4 RULE5 RULE9 RULE15 RULE16
      op_q <= flash_pkg::link_op_t'(avs_writedata_in[2:0]);
      byte_q <= avs_writedata_in[flash_pkg::CMD_BYTE];
    end else begin
      req_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (req_q) begin
      pend_q <= 1'b1;
    end else if (link.done) begin
      pend_q <= 1'b0;
      if (op_q inside {flash_pkg::OP_TBL_RD_LO, flash_pkg::OP_TBL_RD_HI, flash_pkg::OP_CTL_RD}) begin
        rdata_q <= link.rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // events: set wins over the read clear
  always_comb begin
    ev_set = '0;
    ev_set[flash_pkg::EV_LINK] = link.done;
    ev_set[flash_pkg::EV_FLASH] = stall_prev_q && !link.stall;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      events_q <= '0;
      stall_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      stall_prev_q <= link.stall;
      if (accept && avs_read_in && avs_address_in == flash_pkg::REG_EVENTS) begin
        events_q <= (events_q & ~rd_events_q) | ev_set;
      end else begin
        events_q <= events_q | ev_set;
      end
      irq_q <= |(events_q & mask_q);
    end
  end

  assign avs_readdata_out = readdata_q;
  assign avs_waitrequest_out = wait_q;
  assign irq_out = irq_q;
  assign link.req = req_q;
  assign link.op = op_q;
  assign link.byte_mode = byte_q;
  assign link.page = page_q;
  assign link.ea = ea_q;
  assign link.wdata = wdata_q;
endmodule

// *** test/flash_link_properties.sv ***
// Purpose: link-level checks between the core port and the sequencer
// Assumes: one clock, asynchronous active-high reset
// Notes: watches the interface wires only; unlock history kept in two flops
module flash_link_properties (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req,
  input wire flash_pkg::link_op_t op,
  input wire logic [15:0] wdata,
  input wire logic done,
  input wire logic [15:0] rdata,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic k1_q;
  logic k2_q;
  logic is_tbl;
  logic start_req;
  ////////////////////////////////////////////////////////////////////////////
  // k2_q: the two requests before this one were the unlock pair
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      k1_q <= 1'b0;
      k2_q <= 1'b0;
    end else if (req) begin
      k1_q <= op == flash_pkg::OP_KEY_WR && wdata[7:0] == flash_pkg::KEY_FIRST;
      k2_q <= k1_q && op == flash_pkg::OP_KEY_WR && wdata[7:0] == flash_pkg::KEY_SECOND;
    end
  end
  assign is_tbl = op inside {flash_pkg::OP_TBL_WR_LO, flash_pkg::OP_TBL_WR_HI,
                             flash_pkg::OP_TBL_RD_LO, flash_pkg::OP_TBL_RD_HI};
  assign start_req = req && op == flash_pkg::OP_CTL_WR && wdata[flash_pkg::CTL_START] && k2_q;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  property p_tbl_done;
    req && !stall && is_tbl |=> !done ##1 done;
  endproperty
  a_tbl_done: assert property (p_tbl_done) else $error("table access not answered in two");
  property p_ctl_done;
    req && !stall && !is_tbl |=> done;
  endproperty
  a_ctl_done: assert property (p_ctl_done) else $error("control access not answered");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_done_cause;
    done |-> $past(req) || $past(req, 2);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  property p_start_keyed;
    $rose(stall) |-> $past(start_req);
  endproperty
  a_start_keyed: assert property (p_start_keyed) else $error("stall without unlocked start");
  property p_stall_min;
    $rose(stall) |-> stall [*8];
  endproperty
  a_stall_min: assert property (p_stall_min) else $error("operation ended too soon");
  property p_stall_max;
    $rose(stall) |-> ##[1:1000] !stall;
  endproperty
  a_stall_max: assert property (p_stall_max) else $error("operation never finished");
  property p_rdata_hold;
    // table reads load rdata at the taking edge, a cycle before done
    $changed(rdata) |-> $past(req) && !$past(stall);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without request");
  c_tbl: cover property (req && is_tbl);
  c_start: cover property ($rose(stall));
  c_rd_hi: cover property (done && op == flash_pkg::OP_TBL_RD_HI);
endmodule

// *** test/flash_self_program_sequencer_test.sv ***
// Purpose: end-to-end test of core port and sequencer over Avalon-MM
// Assumes: 40 MHz clock; shortened oscillator counts 8/8/8
// Notes: link completion is found by polling the state register
`define CHK(nm, exp, act) \
  begin \
    check_count++; \
    if ((act) !== (exp)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, act); \
    end \
  end
module flash_self_program_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in;
  logic rst_in;
  logic [4:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wait_rq;
  logic irq;
  logic busy;
  logic [31:0] got;
  int fail_count;
  int check_count;
  flash_link_if flash_link_if_i ();
  // word writes kept at 8 too so every operation outlasts the minimum stall check
  flash_sequencer #(.ROW_FRC_CYCLES(8), .PAGE_FRC_CYCLES(8), .WORD_FRC_CYCLES(8))
    flash_sequencer_i (.mclk_in(mclk_in), .rst_in(rst_in), .oscillator_tuning_field_in(6'h00),
    .flash_busy_out(busy), .link(flash_link_if_i.device));
  flash_core_port flash_core_port_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq), .irq_out(irq),
    .link(flash_link_if_i.core));
  flash_link_properties flash_link_properties_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .req(flash_link_if_i.req), .op(flash_link_if_i.op), .wdata(flash_link_if_i.wdata),
    .done(flash_link_if_i.done), .rdata(flash_link_if_i.rdata), .stall(flash_link_if_i.stall));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge mclk_in); while (wait_rq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic cmd(input flash_pkg::link_op_t op, input logic b, input logic [15:0] d);
    bus(1'b1, flash_pkg::REG_WDATA, {16'h0000, d});
    bus(1'b1, flash_pkg::REG_CMD, {27'h0000000, b, 1'b0, op});
    do bus(1'b0, flash_pkg::REG_STATE, 32'h00000000); while (got[1:0] !== 2'b00);
  endtask
  task automatic tw(input logic [15:0] ea, input logic [15:0] lo, input logic [15:0] hi);
    bus(1'b1, flash_pkg::REG_EA, {16'h0000, ea});
    cmd(flash_pkg::OP_TBL_WR_LO, 1'b0, lo);
    cmd(flash_pkg::OP_TBL_WR_HI, 1'b0, hi);
  endtask
  task automatic start(input logic [15:0] ctl);
    cmd(flash_pkg::OP_KEY_WR, 1'b0, {8'h00, flash_pkg::KEY_FIRST});
    cmd(flash_pkg::OP_KEY_WR, 1'b0, {8'h00, flash_pkg::KEY_SECOND});
    cmd(flash_pkg::OP_CTL_WR, 1'b0, ctl);
  endtask
  task automatic rdw(input logic [7:0] pg, input logic [15:0] ea,
                     input flash_pkg::link_op_t op, input logic b);
    bus(1'b1, flash_pkg::REG_PAGE, {24'h000000, pg});
    bus(1'b1, flash_pkg::REG_EA, {16'h0000, ea});
    cmd(op, b, 16'h0000);
    bus(1'b0, flash_pkg::REG_RDATA, 32'h00000000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge mclk_in);
    fail_count++;
    $display("watchdog expired");
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] regs [8];
    logic [15:0] bea [6];
    logic [15:0] bexp [6];
    regs = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
    bea = '{16'h0200, 16'h0200, 16'h0201, 16'h0200, 16'h0200, 16'h0201};
    bexp = '{16'h1234, 16'h0034, 16'h0012, 16'h0056, 16'h0056, 16'h0000};
    fail_count = 0;
    check_count = 0;
    rst_in = 1'b1;
    addr = 5'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h00000000;
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    `CHK("irq after reset", 1'b0, irq);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, regs[i], 32'h00000000);
      `CHK("register after reset", 32'h00000000, got);
    end
    $display("reset test done");
    // erase page 0; only the flash-finished event may raise irq
    bus(1'b1, flash_pkg::REG_MASK, 32'h00000002);
    tw(16'h0000, 16'h0000, 16'h0000);
    `CHK("masked irq", 1'b0, irq);
    start(16'hC042);
    `CHK("irq after erase", 1'b1, irq);
    `CHK("busy after erase", 1'b0, busy);
    bus(1'b0, flash_pkg::REG_EVENTS, 32'h00000000);
    `CHK("events", 32'h00000003, got);
    @(posedge mclk_in);
    `CHK("irq cleared", 1'b0, irq);
    rdw(8'h00, 16'h03FE, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("erased last word", 32'h0000FFFF, got);
    cmd(flash_pkg::OP_CTL_RD, 1'b0, 16'h0000);
    bus(1'b0, flash_pkg::REG_RDATA, 32'h00000000);
    `CHK("start bit cleared", 32'h00004042, got);
    $display("erase test done");
    // row 1 of page 0: 64 words loaded in order, array untouched until start
    for (int i = 0; i < 64; i++) tw(16'h0080 + 16'(2 * i), 16'h1000 + 16'(i), 16'h0040 + 16'(i));
    rdw(8'h00, 16'h0080, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("array before start", 32'h0000FFFF, got);
    start(16'hC001);
    rdw(8'h00, 16'h0080, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("row first low", 32'h00001000, got);
    rdw(8'h00, 16'h00FE, flash_pkg::OP_TBL_RD_HI, 1'b0);
    `CHK("row last high", 32'h0000007F, got);
    rdw(8'h00, 16'h0100, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("next row untouched", 32'h0000FFFF, got);
    rdw(8'h00, 16'h007E, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("row before untouched", 32'h0000FFFF, got);
    $display("row test done");
    // single word, then word and byte reads of both halves
    tw(16'h0200, 16'h1234, 16'h0056);
    start(16'hC003);
    for (int i = 0; i < 6; i++) begin
      rdw(8'h00, bea[i], (i < 3) ? flash_pkg::OP_TBL_RD_LO : flash_pkg::OP_TBL_RD_HI,
          i != 0 && i != 3);
      `CHK("word and byte read", {16'h0000, bexp[i]}, got);
    end
    rdw(8'h01, 16'h0200, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("other table page", 32'h00000000, got);
    $display("word test done");
    // start after only one key must be refused
    tw(16'h0204, 16'h0000, 16'h0000);
    cmd(flash_pkg::OP_KEY_WR, 1'b0, {8'h00, flash_pkg::KEY_FIRST});
    cmd(flash_pkg::OP_CTL_WR, 1'b0, 16'hC003);
    cmd(flash_pkg::OP_CTL_RD, 1'b0, 16'h0000);
    bus(1'b0, flash_pkg::REG_RDATA, 32'h00000000);
    `CHK("refused start", 32'h00006003, got);
    rdw(8'h00, 16'h0204, flash_pkg::OP_TBL_RD_LO, 1'b0);
    `CHK("refused array", 32'h0000FFFF, got);
    $display("unlock test done");
    complete_run();
  end
endmodule
